/* logic/cps_pkg.sv */
`default_nettype none
package cps_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int PC_W     = 12;
   localparam int PC_LO_W  = 8;
   localparam int INSTR_W  = 16;
   localparam int DATA_W   = 8;
   localparam int AXI_AW   = 4;
   localparam int STACK_D  = 6;
   localparam int PHASES   = 4;

   // ----------------------------------------------------------------
   // Reset values and vectors
   // ----------------------------------------------------------------
   localparam logic [11:0] RESET_VECTOR = 12'h000;
   localparam logic [11:0] IRQ_VECTOR   = 12'h004;
   localparam logic [1:0]  PH_T1        = 2'h0;
   localparam logic [1:0]  PH_T4        = 2'h3;
   localparam logic        RUN_RESET    = 1'h1;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_PC_LOW = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_PC     = 4'h8;
   localparam logic [3:0] OFS_CTRL   = 4'hC;

   // Status word fields
   localparam int ST_FLAGS_LSB = 0;
   localparam int ST_LEVEL_LSB = 4;
   localparam int ST_FULL_BIT  = 7;
   localparam int ST_ACC_LSB   = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Instruction classes, instr[15:12]
   // ----------------------------------------------------------------
   localparam logic [3:0] CLS_NOP   = 4'h0;
   localparam logic [3:0] CLS_ALU   = 4'h1;
   localparam logic [3:0] CLS_ALU_X = 4'h2;
   localparam logic [3:0] CLS_JMP   = 4'h3;
   localparam logic [3:0] CLS_CALL  = 4'h4;
   localparam logic [3:0] CLS_RTN   = 4'h5;
   localparam logic [3:0] CLS_IRTN  = 4'h6;
   localparam logic [3:0] CLS_SKZ   = 4'h7;
   localparam logic [3:0] CLS_PGJ   = 4'h8;

   // ----------------------------------------------------------------
   // ALU operations, instr[11:8]
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CPS_ADD, CPS_ADC, CPS_SUB, CPS_SBC, CPS_DAA, CPS_AND, CPS_OR, CPS_XOR,
      CPS_CPL, CPS_RR, CPS_RRC, CPS_RL, CPS_RLC, CPS_INC, CPS_DEC, CPS_MOV
   } cps_alu_op_t;

endpackage : cps_pkg
`default_nettype wire

/* logic/cps_alu_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface cps_alu_if;
   cps_pkg::cps_alu_op_t op;
   logic [7:0]           a;
   logic [7:0]           b;
   logic                 cin;
   logic                 acin;
   logic [7:0]           y;
   logic                 cout;
   logic                 acout;
   logic                 zout;
   logic                 ovout;

   modport core (output op, a, b, cin, acin, input y, cout, acout, zout, ovout);
   modport alu  (input op, a, b, cin, acin, output y, cout, acout, zout, ovout);
endinterface : cps_alu_if
`default_nettype wire

/* logic/cps_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module cps_alu (
   cps_alu_if.alu alu
);

   function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y,
                                       input logic c);
      add9 = {1'b0, x} + {1'b0, y} + {8'h00, c};
   endfunction : add9

   logic [8:0] sum;
   logic [4:0] half;
   logic [7:0] bb;
   logic       ci;

   always_comb begin
      bb        = alu.b;
      ci        = 1'b0;
      alu.y     = alu.a;
      alu.cout  = alu.cin;
      alu.acout = alu.acin;
      alu.ovout = 1'b0;
      // Subtract is add of the complement; carry out set means no borrow
      unique case (alu.op)
         cps_pkg::CPS_ADD: ci = 1'b0;
         cps_pkg::CPS_ADC: ci = alu.cin;
         cps_pkg::CPS_SUB: begin
            bb = ~alu.b;
            ci = 1'b1;
         end
         cps_pkg::CPS_SBC: begin
            bb = ~alu.b;
            ci = alu.cin;
         end
         cps_pkg::CPS_INC: begin
            bb = 8'h01;
         end
         cps_pkg::CPS_DEC: begin
            bb = 8'hFF;
         end
         default: ci = 1'b0;
      endcase
      sum  = add9(alu.a, bb, ci);
      half = {1'b0, alu.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      unique case (alu.op)
         cps_pkg::CPS_ADD, cps_pkg::CPS_ADC, cps_pkg::CPS_SUB, cps_pkg::CPS_SBC: begin
            alu.y     = sum[7:0];
            alu.cout  = sum[8];
            alu.acout = half[4];
            alu.ovout = (alu.a[7] == bb[7]) && (sum[7] != alu.a[7]);
         end
         cps_pkg::CPS_INC, cps_pkg::CPS_DEC: alu.y = sum[7:0];
         cps_pkg::CPS_DAA: begin
            sum = {1'b0, alu.a};
            if (alu.a[3:0] > 4'h9 || alu.acin) begin
               sum = sum + 9'h006;
            end
            if (sum[7:4] > 4'h9 || alu.cin || sum[8]) begin
               sum = sum + 9'h060;
            end
            alu.y    = sum[7:0];
            alu.cout = sum[8] | alu.cin;
         end
         cps_pkg::CPS_AND: alu.y = alu.a & alu.b;
         cps_pkg::CPS_OR:  alu.y = alu.a | alu.b;
         cps_pkg::CPS_XOR: alu.y = alu.a ^ alu.b;
         cps_pkg::CPS_CPL: alu.y = ~alu.a;
         cps_pkg::CPS_RR:  alu.y = {alu.a[0], alu.a[7:1]};
         cps_pkg::CPS_RL:  alu.y = {alu.a[6:0], alu.a[7]};
         cps_pkg::CPS_RRC: begin
            alu.y    = {alu.cin, alu.a[7:1]};
            alu.cout = alu.a[0];
         end
         cps_pkg::CPS_RLC: begin
            alu.y    = {alu.a[6:0], alu.cin};
            alu.cout = alu.a[7];
         end
         cps_pkg::CPS_MOV: alu.y = alu.b;
      endcase
      alu.zout = (alu.y == 8'h00);
   end

endmodule : cps_alu
`default_nettype wire

/* logic/cps_stack.sv */
`timescale 1ns/100ps
`default_nettype none
module cps_stack #(
   parameter int DEPTH = 6,
   parameter int W     = 12
) (
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   input  wire logic         push_i,
   input  wire logic         pop_i,
   input  wire logic [W-1:0] data_i,
   output logic      [W-1:0] top_o,
   output logic      [2:0]   level_o,
   output logic              full_o
);

   initial begin
      if (DEPTH < 1 || DEPTH > 7) begin
         $error("cps_stack: DEPTH must be 1..7");
      end
   end

   localparam logic [2:0] DEPTH_L = 3'(DEPTH);

   logic [W-1:0] entry [DEPTH];

   // Shift structure: a push while full pushes the oldest entry out
   always_ff @(posedge clk_i) begin
      if (push_i) begin
         entry[0] <= data_i;
         for (int i = 1; i < DEPTH; i++) begin
            entry[i] <= entry[i-1];
         end
      end else if (pop_i) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            entry[i] <= entry[i+1];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         level_o <= 3'h0;
      end else if (push_i && level_o != DEPTH_L) begin
         level_o <= level_o + 3'h1;
      end else if (pop_i && level_o != 3'h0) begin
         level_o <= level_o - 3'h1;
      end
   end

   assign top_o  = entry[0];
   assign full_o = (level_o == DEPTH_L);

endmodule : cps_stack
`default_nettype wire

/* logic/cps_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module cps_seq #(
   parameter int STACK_DEPTH = cps_pkg::STACK_D
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Program memory, combinational read
   output logic [11:0]      imem_addr_o,
   input  wire logic [15:0] imem_data_i,
   // Interrupt logic
   input  wire logic        irq_req_i,
   output logic             irq_ack_o,
   output logic             irq_exit_o,
   output logic [3:0]       phase_o,
   output logic [7:0]       acc_o,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   initial begin
      if (STACK_DEPTH != cps_pkg::STACK_D) begin
         $error("cps_seq: stack depth is fixed at six levels");
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [1:0]  phase;
   logic        run;
   logic [11:0] pc;
   logic [15:0] ir;
   logic        ir_valid;
   logic [15:0] fbuf;
   logic [11:0] fbuf_addr;
   logic        fbuf_valid;
   logic        ext_hold;
   logic [7:0]  acc;
   logic [3:0]  flags;      // {ov, z, ac, c}
   logic        pgj_pend;
   logic [7:0]  pgj_data;

   logic        t1;
   logic        t4;
   logic        exec;
   logic [3:0]  cls;
   logic        br;
   logic [11:0] br_target;
   logic        skip;
   logic        push;
   logic        pop;
   logic [11:0] push_data;
   logic        acc_wr;
   logic        sw_jump;
   logic        ack;
   logic [11:0] stk_top;
   logic [2:0]  stk_level;
   logic        stk_full;

   cps_alu_if alu_bus ();

   cps_alu u_alu (
      .alu (alu_bus.alu)
   );

   cps_stack #(
      .DEPTH (STACK_DEPTH),
      .W     (cps_pkg::PC_W)
   ) u_stack (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .push_i  (push),
      .pop_i   (pop),
      .data_i  (push_data),
      .top_o   (stk_top),
      .level_o (stk_level),
      .full_o  (stk_full)
   );

   // ----------------------------------------------------------------
   // Phase generation
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         phase <= cps_pkg::PH_T1;
      end else if (run) begin
         phase <= phase + 2'h1;
      end
   end

   assign t1      = run && (phase == cps_pkg::PH_T1);
   assign t4      = run && (phase == cps_pkg::PH_T4);
   assign phase_o = run ? (4'h1 << phase) : 4'h0;

   // ----------------------------------------------------------------
   // Execute decision, at the last phase
   // ----------------------------------------------------------------
   assign cls  = ir[15:12];
   // An extended op spends its first cycle waiting, executes in its second
   assign exec = t4 && ir_valid && !(cls == cps_pkg::CLS_ALU_X && !ext_hold);

   assign alu_bus.op   = cps_pkg::cps_alu_op_t'(ir[11:8]);
   assign alu_bus.a    = acc;
   assign alu_bus.b    = ir[7:0];
   assign alu_bus.cin  = flags[0];
   assign alu_bus.acin = flags[1];

   always_comb begin
      br        = 1'b0;
      br_target = pc;
      skip      = 1'b0;
      push      = 1'b0;
      pop       = 1'b0;
      push_data = fbuf_addr;
      acc_wr    = 1'b0;
      irq_exit_o = 1'b0;
      if (exec) begin
         unique case (cls)
            cps_pkg::CLS_ALU, cps_pkg::CLS_ALU_X: acc_wr = 1'b1;
            cps_pkg::CLS_JMP: begin
               br        = 1'b1;
               br_target = ir[11:0];
            end
            cps_pkg::CLS_CALL: begin
               br        = 1'b1;
               br_target = ir[11:0];
               push      = 1'b1;
            end
            cps_pkg::CLS_RTN, cps_pkg::CLS_IRTN: begin
               br        = 1'b1;
               br_target = stk_top;
               pop       = 1'b1;
               irq_exit_o = (cls == cps_pkg::CLS_IRTN);
            end
            cps_pkg::CLS_SKZ: begin
               acc_wr = 1'b1;
               skip   = alu_bus.zout;
            end
            cps_pkg::CLS_PGJ: begin
               br        = 1'b1;
               br_target = {pc[11:8], ir[7:0]};
            end
            default: br = 1'b0;
         endcase
      end
      // Interrupt only between instructions, never while a level is missing
      ack = t4 && !br && !skip && irq_req_i && !stk_full
            && !(ir_valid && cls == cps_pkg::CLS_ALU_X && !ext_hold);
      // Software low-byte write waits behind an instruction's own branch
      sw_jump = t4 && pgj_pend && !br && !skip && !ack;
      if (ack) begin
         push      = 1'b1;
         push_data = fbuf_addr;
      end
   end

   assign irq_ack_o = ack;

   // ----------------------------------------------------------------
   // Program counter and prefetch pipeline
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pc <= cps_pkg::RESET_VECTOR;
      end else if (t1 && !ext_hold) begin
         pc <= pc + 12'h001;
      end else if (br) begin
         pc <= br_target;
      end else if (ack) begin
         pc <= cps_pkg::IRQ_VECTOR;
      end else if (sw_jump) begin
         pc <= {pc[11:8], pgj_data};
      end
   end

   always_ff @(posedge clk_i) begin
      if (t1 && !ext_hold) begin
         fbuf      <= imem_data_i;
         fbuf_addr <= pc;
         ir        <= fbuf;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fbuf_valid <= 1'b0;
         ir_valid   <= 1'b0;
      end else if (t1 && !ext_hold) begin
         fbuf_valid <= 1'b1;
         ir_valid   <= fbuf_valid;
      end else if (br || skip || ack || sw_jump) begin
         // Prefetched word dropped; its slot becomes a dummy cycle
         fbuf_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ext_hold <= 1'b0;
      end else if (t4) begin
         ext_hold <= ir_valid && cls == cps_pkg::CLS_ALU_X && !ext_hold;
      end
   end

   // ----------------------------------------------------------------
   // Accumulator and status flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         acc   <= 8'h00;
         flags <= 4'h0;
      end else if (acc_wr) begin
         acc   <= alu_bus.y;
         flags <= {alu_bus.ovout, alu_bus.zout, alu_bus.acout,
                   alu_bus.cout};
      end
   end

   assign acc_o       = acc;
   assign imem_addr_o = pc;

   // ----------------------------------------------------------------
   // AXI4-Lite write side
   // ----------------------------------------------------------------
   logic wr_take;
   logic rd_take;

   // Address and data are taken together; the master holds whichever came first
   assign wr_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign rd_take       = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_take;

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a[1:0] == 2'h0);
   endfunction : mapped

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cps_pkg::RESP_OKAY;
      end else if (wr_take) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(s_axi_awaddr) ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pgj_pend <= 1'b0;
         pgj_data <= 8'h00;
      end else if (wr_take && s_axi_awaddr == cps_pkg::OFS_PC_LOW && s_axi_wstrb[0]) begin
         // A new write beats the clear of an older one
         pgj_pend <= 1'b1;
         pgj_data <= s_axi_wdata[7:0];
      end else if (sw_jump) begin
         pgj_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         run <= cps_pkg::RUN_RESET;
      end else if (wr_take && s_axi_awaddr == cps_pkg::OFS_CTRL && s_axi_wstrb[0]) begin
         run <= s_axi_wdata[0];
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read side
   // ----------------------------------------------------------------
   logic [31:0] rd_word;

   // Stack contents and level are deliberately absent from the map
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         cps_pkg::OFS_PC_LOW: rd_word[7:0] = pc[7:0];
         cps_pkg::OFS_STATUS: begin
            rd_word[cps_pkg::ST_FLAGS_LSB +: 4] = flags;
            rd_word[cps_pkg::ST_ACC_LSB +: 8]   = acc;
         end
         cps_pkg::OFS_PC:     rd_word[7:0] = {pgj_pend, ext_hold, phase, 4'h0};
         cps_pkg::OFS_CTRL:   rd_word[0]   = run;
         default:             rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= cps_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= mapped(s_axi_araddr) ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : cps_seq
`default_nettype wire

/* verif/cps_seq_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module cps_seq_properties (
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic [11:0] imem_addr_o,
   input wire logic        irq_req_i,
   input wire logic        irq_ack_o,
   input wire logic        irq_exit_o,
   input wire logic [3:0]  phase_o,
   input wire logic [7:0]  acc_o,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_rvalid
);
   // ------------------------------------------------
   // Pipeline, interrupt and bus timing
   // ------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   property p_phase_seq;
      phase_o == 4'h1 |=> phase_o == 4'h2 ##1 phase_o == 4'h4 ##1 phase_o == 4'h8 ##1 phase_o == 4'h1;
   endproperty
   a_phase_seq: assert property (p_phase_seq)
      else $error("phase order broken");
   property p_pc_step;
      phase_o == 4'h1 |=> imem_addr_o == $past(imem_addr_o) + 12'h001;
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("pc not advanced at first phase");
   property p_pc_hold;
      phase_o inside {4'h2, 4'h4} |=> $stable(imem_addr_o);
   endproperty
   a_pc_hold: assert property (p_pc_hold)
      else $error("pc moved in mid cycle");
   property p_reset;
      $past(srst_i) |-> imem_addr_o == 12'h000 && phase_o == 4'h1;
   endproperty
   a_reset: assert property (p_reset)
      else $error("pc or phase wrong after reset");
   property p_ack_t4;
      irq_ack_o |-> phase_o == 4'h8 && irq_req_i;
   endproperty
   a_ack_t4: assert property (p_ack_t4)
      else $error("acknowledge without request or off phase");
   property p_ack_vec;
      irq_ack_o |-> ##[1:4] imem_addr_o == cps_pkg::IRQ_VECTOR;
   endproperty
   a_ack_vec: assert property (p_ack_vec)
      else $error("vector not loaded");
   property p_exit_t4;
      irq_exit_o |-> phase_o == 4'h8;
   endproperty
   a_exit_t4: assert property (p_exit_t4)
      else $error("return pulse off phase");
   property p_acc_t4;
      $changed(acc_o) |-> $past(phase_o) == 4'h8;
   endproperty
   a_acc_t4: assert property (p_acc_t4)
      else $error("accumulator changed outside execute");
   property p_bus_ans;
      (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) || (s_axi_arvalid && !s_axi_rvalid)
         |=> s_axi_bvalid || s_axi_rvalid;
   endproperty
   a_bus_ans: assert property (p_bus_ans)
      else $error("register access not answered");
endmodule : cps_seq_properties
bind cps_seq cps_seq_properties u_cps_seq_properties (
   .clk_i, .srst_i, .imem_addr_o, .irq_req_i, .irq_ack_o, .irq_exit_o, .phase_o, .acc_o,
   .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_rvalid
);
`default_nettype wire

/* verif/cps_prog_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cps_prog_mem_model (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic [11:0] addr_i,
   output logic      [15:0] data_o,
   input  wire logic        irq_set_i,
   output logic             irq_req_o,
   input  wire logic        irq_ack_i,
   input  wire logic        irq_exit_i,
   output logic      [7:0]  ack_cnt_o,
   output logic      [7:0]  exit_cnt_o
);
   logic [15:0] mem [4096];
   initial begin
      foreach (mem[k]) mem[k] = 16'h0000;
   end
   assign data_o = mem[addr_i];
   // Request stays pending until taken, even while the core holds it off
   always_ff @(posedge clk_i) begin
      if (srst_i || irq_ack_i) begin
         irq_req_o <= 1'h0;
      end else if (irq_set_i) begin
         irq_req_o <= 1'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ack_cnt_o  <= 8'h00;
         exit_cnt_o <= 8'h00;
      end else begin
         ack_cnt_o  <= ack_cnt_o + {7'h00, irq_ack_i};
         exit_cnt_o <= exit_cnt_o + {7'h00, irq_exit_i};
      end
   end
endmodule : cps_prog_mem_model
`default_nettype wire

/* verif/cpu_program_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_program_sequencer_tb;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0]  r;
   } cps_exp_t;
   logic        clk_i = 1'h0, srst_i = 1'h1, irq_set = 1'h0;
   logic [11:0] imem_addr_o;
   logic [15:0] imem_data_i;
   logic        irq_req_i, irq_ack_o, irq_exit_o;
   logic [3:0]  phase_o;
   logic [7:0]  acc_o, ack_cnt, exit_cnt, r1, r2, b;
   logic [8:0]  sum;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   cps_exp_t    exp_q[$];
   cps_exp_t    e;
   int          err_total = 0, samples_checked = 0, i;
   logic [27:0] prog [21] = '{28'h0001F05, 28'h0013020, 28'h0041F77, 28'h0056000,
      28'h0201F08, 28'h0214030, 28'h0227208, 28'h0231F99, 28'h0241042, 28'h0253025,
      28'h0305000, 28'h0401F5A, 28'h0413041, 28'h0604061, 28'h0614062, 28'h0624063,
      28'h0634064, 28'h0644065, 28'h0654066, 28'h0663066, 28'h0675000};
   // ------------------------------------------------
   // Design and far side
   // ------------------------------------------------
   cps_seq u_cps_seq (.clk_i, .srst_i, .imem_addr_o, .imem_data_i, .irq_req_i,
      .irq_ack_o, .irq_exit_o, .phase_o, .acc_o, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   cps_prog_mem_model u_cps_prog_mem_model (.clk_i, .srst_i, .addr_i(imem_addr_o),
      .data_o(imem_data_i), .irq_set_i(irq_set), .irq_req_o(irq_req_i),
      .irq_ack_i(irq_ack_o), .irq_exit_i(irq_exit_o), .ack_cnt_o(ack_cnt), .exit_cnt_o(exit_cnt));
   initial forever #10 clk_i = ~clk_i;
   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic conclude;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic hang(input string what);
      err_total++;
      $display("BAD %0t timeout on %s", $time, what);
      conclude();
   endtask : hang
   // Holds every request until its own ready; answer ready stays up until taken
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] r);
      int n;
      exp_q.push_back({d, m, r});
      @(posedge clk_i);
      if (wr) begin
         s_axi_awaddr  <= a;
         s_axi_wdata   <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid  <= 1'h1;
         s_axi_bready  <= 1'h1;
      end else begin
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready  <= 1'h1;
      end
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if ((wr && s_axi_bvalid) || (!wr && s_axi_rvalid)) break;
      end
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
      if (n == 50) hang("bus");
   endtask : axi
   task automatic wait_pc(input logic [11:0] a);
      int n;
      for (n = 0; n < 400 && imem_addr_o !== a; n++) @(posedge clk_i);
      if (n == 400) hang("program address");
      repeat (8) @(posedge clk_i);
   endtask : wait_pc
   always @(posedge clk_i) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         if (exp_q.size() == 0) begin
            check(32'h1, 32'h0, "unexpected answer");
         end else begin
            e = exp_q.pop_front();
            check({30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, e.r}, "resp");
            check(s_axi_rdata & e.m, e.d & e.m, "read data");
         end
      end
   end
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   initial begin
      void'($urandom(32'h5F92));
      repeat (2) @(posedge clk_i);
      foreach (prog[k]) u_cps_prog_mem_model.mem[prog[k][27:16]] = prog[k][15:0];
      srst_i <= 1'h0;
      wait_pc(12'h026);
      axi(1'h0, 4'h4, 32'h4200, 32'hFF00, cps_pkg::RESP_OKAY);
      $display("jump call skip test done");
      axi(1'h1, 4'h0, 32'h40, 32'h0, cps_pkg::RESP_OKAY);
      wait_pc(12'h042);
      axi(1'h0, 4'h4, 32'h5A00, 32'hFF00, cps_pkg::RESP_OKAY);
      $display("low byte jump test done");
      for (i = 0; i < 3; i++) begin
         r1 = 8'($urandom);
         r2 = 8'($urandom);
         b = 8'h80 + 8'(i * 8);
         sum = {1'h0, r1} + {1'h0, r2};
         u_cps_prog_mem_model.mem[{4'h0, b}] = {8'h1F, r1};
         u_cps_prog_mem_model.mem[{4'h0, b + 8'h1}] = {8'h10, r2};
         u_cps_prog_mem_model.mem[{4'h0, b + 8'h2}] = {4'h3, 4'h0, b + 8'h2};
         axi(1'h1, 4'h0, {24'h0, b}, 32'h0, cps_pkg::RESP_OKAY);
         wait_pc({4'h0, b + 8'h3});
         axi(1'h0, 4'h4, {16'h0, sum[7:0], 4'h0, (r1[7] == r2[7]) && (sum[7] != r1[7]),
            sum[7:0] == 8'h0, ({1'h0, r1[3:0]} + {1'h0, r2[3:0]}) > 5'hF, sum[8]},
            32'hFF0F, cps_pkg::RESP_OKAY);
      end
      $display("add and flags test done");
      axi(1'h1, 4'h0, 32'h60, 32'h0, cps_pkg::RESP_OKAY);
      wait_pc(12'h067);
      irq_set <= 1'h1;
      @(posedge clk_i);
      irq_set <= 1'h0;
      repeat (40) @(posedge clk_i);
      check({24'h0, ack_cnt}, 32'h0, "acknowledge while stack full");
      axi(1'h1, 4'h0, 32'h67, 32'h0, cps_pkg::RESP_OKAY);
      for (i = 0; i < 200 && exit_cnt === 8'h00; i++) @(posedge clk_i);
      if (i == 200) hang("interrupt return");
      check({24'h0, ack_cnt}, 32'h1, "acknowledge count");
      repeat (8) @(posedge clk_i);
      axi(1'h0, 4'h4, 32'h7700, 32'hFF00, cps_pkg::RESP_OKAY);
      check({24'h0, acc_o}, 32'h77, "accumulator output");
      $display("full stack interrupt test done");
      axi(1'h0, 4'h2, 32'h0, 32'hFFFF_FFFF, cps_pkg::RESP_SLVERR);
      $display("misaligned read test done");
      conclude();
   end
endmodule : cpu_program_sequencer_tb
`default_nettype wire
